// *** design/sbg_pkg.sv ***
// Package: register map, field layout, reset values and prescaler taps
package sbg_pkg;
   // Register byte addresses
   localparam logic [31:0] ADDR_MODE_EXTRA0 = 32'hfffff205;
   localparam logic [31:0] ADDR_MODE_EXTRA1 = 32'hfffff20d;
   localparam logic [31:0] ADDR_MODE_EXTRA3 = 32'hfffff285;
   localparam logic [31:0] ADDR_CHAN_MODE4 = 32'hfffff289;
   localparam logic [31:0] ADDR_BAUD_CTRL4 = 32'hfffff28b;
   localparam logic [31:0] ADDR_FRACTION_K4 = 32'hfffff28c;
   localparam logic [31:0] ADDR_MODE_EXTRA4 = 32'hfffff28d;

   // Baud control, fraction K and channel mode field positions
   localparam int BAUD_FRAC_EN_BIT = 6;
   localparam int BAUD_SRC_HI = 5;
   localparam int BAUD_SRC_LO = 4;
   localparam int BAUD_N_HI = 3;
   localparam int BAUD_N_LO = 0;
   localparam int K_HI = 3;
   localparam int K_LO = 0;
   localparam int MODE_HI = 1;
   localparam int MODE_LO = 0;

   // Extra mode field positions
   localparam int IDLE_RUN_BIT = 7;
   localparam int DUPLEX_BIT = 6;

   // Values after reset
   localparam logic [1:0] RESET_SRC = 2'h0;
   localparam logic [3:0] RESET_N = 4'h0;
   localparam logic RESET_FRAC_EN = 1'b0;
   localparam logic [3:0] RESET_K = 4'h0;
   localparam logic [1:0] RESET_MODE = 2'h0;
   localparam logic RESET_IDLE_RUN = 1'b0;
   localparam logic RESET_DUPLEX = 1'b0;

   // Channel modes
   localparam logic [1:0] MODE_SYNC_IO = 2'h0;
   localparam logic [1:0] MODE_UART7 = 2'h1;
   localparam logic [1:0] MODE_UART8 = 2'h2;

   // Prescaler: tap fires when masked low bits are all ones
   localparam int PRE_W = 7;
   localparam logic [6:0] TAP_MASK [0:3] = '{7'h01, 7'h07, 7'h1f, 7'h7f};

   // Divisor arithmetic
   localparam logic [4:0] N_CODE_ZERO_VALUE = 5'h10;
   localparam logic [4:0] FRAC_SPAN = 5'h10;
endpackage

// *** design/sbg_div_if.sv ***
// Interface: control path between register bank and baud divider
`timescale 1ns/1ps
interface sbg_div_if;
   logic tap_tick;
   logic [3:0] n_code;
   logic [3:0] k_val;
   logic frac_on;
   logic run;
   logic baud_tick;

   // Register side drives settings, divider returns the tick
   modport ctl (
      output tap_tick, n_code, k_val, frac_on, run,
      input baud_tick
   );
   modport div (
      input tap_tick, n_code, k_val, frac_on, run,
      output baud_tick
   );
endinterface

// *** design/sbg_frac_div.sv ***
// Baud divider: divide tap ticks by N or N+(16-K)/16
`timescale 1ns/1ps
module sbg_frac_div (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Settings and tick
   sbg_div_if.div bus
);
   logic [4:0] cnt;
   logic [3:0] phase;
   logic tick;
   wire [4:0] n_val;
   wire [4:0] quota;
   wire frac_ok;
   wire stretch;
   wire [4:0] len;

   // Code 0 means sixteen
   assign n_val = (bus.n_code == 4'h0) ? sbg_pkg::N_CODE_ZERO_VALUE :
      {1'b0, bus.n_code};
   // Invalid fraction settings fall back to plain N
   assign frac_ok = bus.frac_on && (bus.n_code > 4'h1) &&
      (bus.k_val != 4'h0);
   assign quota = sbg_pkg::FRAC_SPAN - {1'b0, bus.k_val};
   // First 16-K periods of each 16 get one extra tap
   assign stretch = frac_ok && ({1'b0, phase} < quota);
   assign len = n_val + {4'h0, stretch};
   assign bus.baud_tick = tick;

   // Period and phase counters; no state kept beyond 16 periods
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 5'h00;
         phase <= 4'h0;
         tick <= 1'b0;
      end else if (!bus.run) begin
         cnt <= 5'h00;
         phase <= 4'h0;
         tick <= 1'b0;
      end else begin
         tick <= 1'b0;
         if (bus.tap_tick) begin
            if (cnt >= len - 5'h01) begin // Ends at once if N shrank
               cnt <= 5'h00;
               tick <= 1'b1;
               phase <= phase + 4'h1;
            end else begin
               cnt <= cnt + 5'h01;
            end
         end
      end
   end

   // Helper: taps per period, valid after one full stable period
   logic [4:0] tc;
   logic seen;
   logic [12:0] cfg_q;
   wire [12:0] cfg;
   wire [3:0] prev_phase;
   wire meas_ok;
   assign cfg = {bus.n_code, bus.k_val, bus.frac_on, bus.run, 3'h0};
   assign prev_phase = phase - 4'h1;
   // Skip the tick that lands while settings are still moving
   assign meas_ok = seen && (cfg == cfg_q);
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         tc <= 5'h00;
         seen <= 1'b0;
         cfg_q <= 13'h0000;
      end else begin
         cfg_q <= cfg;
         if (!bus.run || cfg != cfg_q) begin
            seen <= 1'b0;
            tc <= 5'h00;
         end else if (tick) begin
            seen <= 1'b1;
            tc <= {4'h0, bus.tap_tick};
         end else begin
            tc <= tc + {4'h0, bus.tap_tick};
         end
      end
   end

   property p_div_n;
      @(posedge ref_clk) disable iff (!rst_n)
      (tick && meas_ok && !frac_ok) |-> (tc == n_val);
   endproperty
   a_div_n: assert property (p_div_n)
      else $error("plain divide period differs from N");

   property p_div_frac;
      @(posedge ref_clk) disable iff (!rst_n)
      (tick && meas_ok && frac_ok) |->
         (tc == n_val || tc == n_val + 5'h01);
   endproperty
   a_div_frac: assert property (p_div_frac)
      else $error("fractional period is neither N nor N+1");

   property p_frac_spread;
      @(posedge ref_clk) disable iff (!rst_n)
      (tick && meas_ok && frac_ok) |->
         ((tc == n_val + 5'h01) == ({1'b0, prev_phase} < quota));
   endproperty
   a_frac_spread: assert property (p_frac_spread)
      else $error("stretched period in wrong phase slot");
endmodule

// *** design/sbg_top.sv ***
// Baud rate generator for serial channel 4 and extra mode bits
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
module sbg_top (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Register port
   input wire logic [31:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Power state from the clock controller, same clock
   input wire logic idle_state,
   // Channel controls
   output logic baud_tick,
   output logic [3:0] run_enable,
   output logic [1:0] duplex_full,
   output logic uart_mode
);
   // Address match, shared by write and read decoding
   function automatic logic reg_hit(input logic [31:0] addr,
      input logic [31:0] off);
      return addr == off;
   endfunction

   // Tap condition on the free prescaler
   function automatic logic tap_hit(input logic [6:0] cnt,
      input logic [6:0] mask);
      return (cnt & mask) == mask;
   endfunction

   sbg_div_if div_bus ();

   logic [6:0] pre;
   logic [3:0] tap_vec;
   logic [1:0] clk_src;
   logic [3:0] n_code;
   logic frac_en;
   logic [3:0] k_val;
   logic [1:0] chan_mode;
   logic [3:0] idle_run;
   logic [7:0] rd_mux;

   // Address decode
   wire hit_ex0 = reg_hit(reg_addr, sbg_pkg::ADDR_MODE_EXTRA0);
   wire hit_ex1 = reg_hit(reg_addr, sbg_pkg::ADDR_MODE_EXTRA1);
   wire hit_ex3 = reg_hit(reg_addr, sbg_pkg::ADDR_MODE_EXTRA3);
   wire hit_ex4 = reg_hit(reg_addr, sbg_pkg::ADDR_MODE_EXTRA4);
   wire hit_mode = reg_hit(reg_addr, sbg_pkg::ADDR_CHAN_MODE4);
   wire hit_baud = reg_hit(reg_addr, sbg_pkg::ADDR_BAUD_CTRL4);
   wire hit_k = reg_hit(reg_addr, sbg_pkg::ADDR_FRACTION_K4);

   // Mode decode; fraction forced off outside UART as a safety net
   wire uart_sel = (chan_mode == sbg_pkg::MODE_UART7) ||
      (chan_mode == sbg_pkg::MODE_UART8);
   // Channel 4 generator stops in IDLE unless its run bit is set
   wire run4 = !(idle_state && !idle_run[3]);
   wire [3:0] next_run_enable = ~({4{idle_state}} & ~idle_run);

   // Free prescaler, taps give T0, T2, T8 and T32 enables
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pre <= 7'h00;
      end else begin
         pre <= pre + 7'h01;
      end
   end

   generate
      for (genvar i = 0; i < 4; i++) begin : g_tap
         assign tap_vec[i] = tap_hit(pre, sbg_pkg::TAP_MASK[i]);
      end
   endgenerate

   // Settings to the divider
   assign div_bus.tap_tick = tap_vec[clk_src];
   assign div_bus.n_code = n_code;
   assign div_bus.k_val = k_val;
   assign div_bus.frac_on = frac_en && uart_sel;
   assign div_bus.run = run4;
   assign baud_tick = div_bus.baud_tick;

   sbg_frac_div u_div (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .bus(div_bus)
   );

   // Baud control; bit 7 is not stored
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         clk_src <= sbg_pkg::RESET_SRC;
         n_code <= sbg_pkg::RESET_N;
         frac_en <= sbg_pkg::RESET_FRAC_EN;
      end else if (reg_wr && hit_baud) begin
         clk_src <= reg_wdata[sbg_pkg::BAUD_SRC_HI:sbg_pkg::BAUD_SRC_LO];
         n_code <= reg_wdata[sbg_pkg::BAUD_N_HI:sbg_pkg::BAUD_N_LO];
         frac_en <= reg_wdata[sbg_pkg::BAUD_FRAC_EN_BIT];
      end
   end

   // Fraction K and channel mode
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         k_val <= sbg_pkg::RESET_K;
         chan_mode <= sbg_pkg::RESET_MODE;
      end else begin
         if (reg_wr && hit_k) begin
            k_val <= reg_wdata[sbg_pkg::K_HI:sbg_pkg::K_LO];
         end
         if (reg_wr && hit_mode) begin
            chan_mode <= reg_wdata[sbg_pkg::MODE_HI:sbg_pkg::MODE_LO];
         end
      end
   end

   // Extra mode bits; index 0,1,2,3 is channel 0,1,3,4
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         idle_run <= {4{sbg_pkg::RESET_IDLE_RUN}};
         duplex_full <= {2{sbg_pkg::RESET_DUPLEX}};
      end else begin
         if (reg_wr && hit_ex0) begin
            idle_run[0] <= reg_wdata[sbg_pkg::IDLE_RUN_BIT];
            duplex_full[0] <= reg_wdata[sbg_pkg::DUPLEX_BIT];
         end
         if (reg_wr && hit_ex1) begin
            idle_run[1] <= reg_wdata[sbg_pkg::IDLE_RUN_BIT];
            duplex_full[1] <= reg_wdata[sbg_pkg::DUPLEX_BIT];
         end
         if (reg_wr && hit_ex3) begin
            idle_run[2] <= reg_wdata[sbg_pkg::IDLE_RUN_BIT];
         end
         if (reg_wr && hit_ex4) begin
            idle_run[3] <= reg_wdata[sbg_pkg::IDLE_RUN_BIT];
         end
      end
   end

   // Read select; unimplemented bits and unmapped addresses read zero
   assign rd_mux =
      hit_ex0 ? {idle_run[0], duplex_full[0], 6'h00} :
      hit_ex1 ? {idle_run[1], duplex_full[1], 6'h00} :
      hit_ex3 ? {idle_run[2], 7'h00} :
      hit_ex4 ? {idle_run[3], 7'h00} :
      hit_mode ? {6'h00, chan_mode} :
      hit_baud ? {1'b0, frac_en, clk_src, n_code} :
      hit_k ? {4'h0, k_val} :
      8'h00;

   // Read data and registered channel controls
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
         run_enable <= 4'hf;
         uart_mode <= 1'b0;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : 8'h00;
         run_enable <= next_run_enable;
         uart_mode <= uart_sel;
      end
   end

   property p_tap_t0;
      @(posedge ref_clk) disable iff (!rst_n)
      (clk_src == 2'h0 && div_bus.tap_tick) |=> !div_bus.tap_tick;
   endproperty
   a_tap_t0: assert property (p_tap_t0)
      else $error("T0 tap fired on two adjacent cycles");

   property p_tap_t32;
      @(posedge ref_clk) disable iff (!rst_n)
      (clk_src == 2'h3 && div_bus.tap_tick && !reg_wr) |=>
         !tap_vec[3] [*8];
   endproperty
   a_tap_t32: assert property (p_tap_t32)
      else $error("T32 tap fired too soon");

   property p_duplex;
      @(posedge ref_clk) disable iff (!rst_n)
      (reg_wr && hit_ex1) |=> ##1
         (duplex_full[1] == $past(reg_wdata[6], 2)) || $past(reg_wr);
   endproperty
   a_duplex: assert property (p_duplex)
      else $error("duplex select did not follow write");

   property p_idle_stop;
      @(posedge ref_clk) disable iff (!rst_n)
      (idle_state && !idle_run[3]) |=> (!baud_tick && !run_enable[3]);
   endproperty
   a_idle_stop: assert property (p_idle_stop)
      else $error("channel 4 kept running in IDLE");

   property p_ch3_read;
      @(posedge ref_clk) disable iff (!rst_n)
      (reg_rd && hit_ex3) |=> (reg_rdata[6:0] == 7'h00) &&
         (reg_rdata[7] == idle_run[2]);
   endproperty
   a_ch3_read: assert property (p_ch3_read)
      else $error("channel 3 extra mode read wrong");

   property p_frac_uart;
      @(posedge ref_clk) disable iff (!rst_n)
      div_bus.frac_on |-> (chan_mode == 2'h1 || chan_mode == 2'h2);
   endproperty
   a_frac_uart: assert property (p_frac_uart)
      else $error("fraction active outside UART mode");

   // Register field stores; each write lands one cycle later
   property p_src_write;
      @(posedge ref_clk) disable iff (!rst_n)
      (reg_wr && hit_baud) |=> (clk_src == $past(reg_wdata[5:4]));
   endproperty
   a_src_write: assert property (p_src_write)
      else $error("clock source field not stored");

   property p_n_write;
      @(posedge ref_clk) disable iff (!rst_n)
      (reg_wr && hit_baud) |=> (n_code == $past(reg_wdata[3:0]));
   endproperty
   a_n_write: assert property (p_n_write)
      else $error("divisor field not stored");

   property p_frac_write;
      @(posedge ref_clk) disable iff (!rst_n)
      (reg_wr && hit_baud) |=> (frac_en == $past(reg_wdata[6]));
   endproperty
   a_frac_write: assert property (p_frac_write)
      else $error("fraction enable not stored");

   property p_k_write;
      @(posedge ref_clk) disable iff (!rst_n)
      (reg_wr && hit_k) |=> (k_val == $past(reg_wdata[3:0]));
   endproperty
   a_k_write: assert property (p_k_write)
      else $error("K field not stored");

   property p_duplex0;
      @(posedge ref_clk) disable iff (!rst_n)
      (reg_wr && hit_ex0) |=> (duplex_full[0] == $past(reg_wdata[6]));
   endproperty
   a_duplex0: assert property (p_duplex0)
      else $error("channel 0 duplex select not stored");

   property p_idle4;
      @(posedge ref_clk) disable iff (!rst_n)
      (reg_wr && hit_ex4) |=> (idle_run[3] == $past(reg_wdata[7]));
   endproperty
   a_idle4: assert property (p_idle4)
      else $error("channel 4 idle run bit not stored");

   // Outside IDLE every channel runs, whatever its run bit
   property p_run_awake;
      @(posedge ref_clk) disable iff (!rst_n)
      (!idle_state) |=> (run_enable == 4'hf);
   endproperty
   a_run_awake: assert property (p_run_awake)
      else $error("channel stopped outside IDLE");

   // Read side: absent bits stay zero; UART flag off in sync mode
   property p_ch4_read;
      @(posedge ref_clk) disable iff (!rst_n)
      (reg_rd && hit_ex4) |=> (reg_rdata[6:0] == 7'h00);
   endproperty
   a_ch4_read: assert property (p_ch4_read)
      else $error("channel 4 extra mode low bits not zero");

   property p_baud_bit7;
      @(posedge ref_clk) disable iff (!rst_n)
      (reg_rd && hit_baud) |=> !reg_rdata[7];
   endproperty
   a_baud_bit7: assert property (p_baud_bit7)
      else $error("baud control bit 7 read as one");

   property p_sync_flag;
      @(posedge ref_clk) disable iff (!rst_n)
      (chan_mode == sbg_pkg::MODE_SYNC_IO) |=> !uart_mode;
   endproperty
   a_sync_flag: assert property (p_sync_flag)
      else $error("UART flag set in synchronous mode");

   // Tap spacing of the middle taps
   property p_tap_t2;
      @(posedge ref_clk) disable iff (!rst_n)
      (clk_src == 2'h1 && div_bus.tap_tick) |=> !tap_vec[1] [*7];
   endproperty
   a_tap_t2: assert property (p_tap_t2)
      else $error("second tap fired too soon");

   property p_tap_t8;
      @(posedge ref_clk) disable iff (!rst_n)
      (clk_src == 2'h2 && div_bus.tap_tick) |=> !tap_vec[2] [*8];
   endproperty
   a_tap_t8: assert property (p_tap_t8)
      else $error("third tap fired too soon");
endmodule

// *** sim/tb.sv ***
// Self-checking bench for the serial baud rate generator block
`timescale 1ns/1ps
module tb;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [31:0] reg_addr = 32'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic idle_state = 1'b0;
   logic baud_tick;
   logic [3:0] run_enable;
   logic [1:0] duplex_full;
   logic uart_mode;
   int fails = 0;
   int checked = 0;
   int cycles = 0;
   logic [7:0] rnd = 8'h58;
   logic [31:0] addrs [0:7] = '{sbg_pkg::ADDR_MODE_EXTRA0,
      sbg_pkg::ADDR_MODE_EXTRA1, sbg_pkg::ADDR_MODE_EXTRA3,
      sbg_pkg::ADDR_CHAN_MODE4, sbg_pkg::ADDR_BAUD_CTRL4,
      sbg_pkg::ADDR_FRACTION_K4, sbg_pkg::ADDR_MODE_EXTRA4, 32'hfffff28e};

   sbg_top u_sbg_top (
      .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .idle_state(idle_state),
      .baud_tick(baud_tick), .run_enable(run_enable),
      .duplex_full(duplex_full), .uart_mode(uart_mode)
   );

   // 40 MHz clock
   always #12.5 ref_clk = ~ref_clk;

   // Hang guard, well above the longest measurement
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 90000) begin
         fails++;
         end_of_test();
      end
   end

   // Random source: maximal 8-bit shift register, never stuck at zero
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction

   // Bits that hold data at each address; the rest read back as zero
   function automatic logic [7:0] reg_mask(input logic [31:0] a);
      case (a)
         sbg_pkg::ADDR_MODE_EXTRA0: return 8'hc0;
         sbg_pkg::ADDR_MODE_EXTRA1: return 8'hc0;
         sbg_pkg::ADDR_MODE_EXTRA3: return 8'h80;
         sbg_pkg::ADDR_MODE_EXTRA4: return 8'h80;
         sbg_pkg::ADDR_CHAN_MODE4: return 8'h03;
         sbg_pkg::ADDR_BAUD_CTRL4: return 8'h7f;
         sbg_pkg::ADDR_FRACTION_K4: return 8'h0f;
         default: return 8'h00;
      endcase
   endfunction

   // Writes software may make: bit 7 and fraction off, no N of 1
   function automatic logic [7:0] legal(input logic [31:0] a,
      input logic [7:0] v);
      if (a != sbg_pkg::ADDR_BAUD_CTRL4) begin
         return v;
      end
      return {2'h0, v[5:4], (v[3:0] == 4'h1) ? 4'h2 : v[3:0]};
   endfunction

   // Cycles between ticks: N taps, tap period 2/8/32/128 cycles
   function automatic int tick_gap(input logic [1:0] src, input logic [3:0] n);
      int nv;
      nv = (n == 4'h0) ? 16 : int'(n);
      return nv * (2 << (2 * int'(src)));
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string what);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t %s: seen %0h expected %0h", $time, what, seen,
                  exp);
      end
   endtask

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic do_reset;
      rst_n <= 1'b0;
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
   endtask

   task automatic reg_write(input logic [31:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   // Read data is sampled in the cycle after the strobe only
   task automatic reg_read(input logic [31:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      d = reg_rdata;
   endtask

   // Cycles up to and including the next tick, bounded
   task automatic gap(output int n);
      n = 0;
      do begin
         @(negedge ref_clk);
         n++;
      end while (baud_tick !== 1'b1 && n < 5000);
   endtask

   // Skip two periods that may mix settings, then sum sixteen periods
   task automatic run16(input int lg, output int sum, output int longs);
      int g;
      gap(g);
      gap(g);
      sum = 0;
      longs = 0;
      repeat (16) begin
         gap(g);
         sum += g;
         if (g == lg) longs++;
      end
   endtask

   initial begin
      logic [7:0] d;
      logic [7:0] v;
      logic [31:0] a;
      logic [3:0] nn;
      logic [3:0] kk;
      int sum;
      int longs;
      int ticks;
      do_reset();
      @(negedge ref_clk);
      check(run_enable, 4'hf, "run after reset");
      check(duplex_full, 2'h0, "duplex after reset");
      check(uart_mode, 1'b0, "mode after reset");
      for (int i = 0; i < 8; i++) begin
         reg_read(addrs[i], d);
         check(d, 8'h00, "reset value");
      end
      // Random writes over all places, an unmapped one included
      repeat (32) begin
         rnd = lfsr(rnd);
         a = addrs[rnd[2:0]];
         rnd = lfsr(rnd);
         v = legal(a, rnd);
         reg_write(a, v);
         reg_read(a, d);
         check(d, v & reg_mask(a), "readback");
      end
      // UART mode flag for every mode code
      for (int m = 0; m < 4; m++) begin
         reg_write(sbg_pkg::ADDR_CHAN_MODE4, 8'(m));
         repeat (2) @(negedge ref_clk);
         check(uart_mode, 1'(m == 1 || m == 2), "uart flag");
      end
      // Duplex and idle run bits, channel 4 stopped in idle
      reg_write(sbg_pkg::ADDR_BAUD_CTRL4, 8'h02);
      reg_write(sbg_pkg::ADDR_MODE_EXTRA0, 8'h40);
      reg_write(sbg_pkg::ADDR_MODE_EXTRA1, 8'h80);
      reg_write(sbg_pkg::ADDR_MODE_EXTRA3, 8'h80);
      reg_write(sbg_pkg::ADDR_MODE_EXTRA4, 8'h00);
      @(posedge ref_clk);
      idle_state <= 1'b1;
      repeat (3) @(negedge ref_clk);
      check(duplex_full, 2'h1, "duplex bits");
      check(run_enable, 4'h6, "idle run bits");
      ticks = 0;
      repeat (40) begin
         @(negedge ref_clk);
         if (baud_tick === 1'b1) ticks++;
      end
      check(ticks, 0, "ticks in idle");
      @(posedge ref_clk);
      idle_state <= 1'b0;
      repeat (3) @(negedge ref_clk);
      check(run_enable, 4'hf, "run after idle");
      // UART mode so that the fraction enable written later takes effect
      reg_write(sbg_pkg::ADDR_CHAN_MODE4, {6'h00, sbg_pkg::MODE_UART8});
      for (int s = 0; s < 4; s++) begin
         reg_write(sbg_pkg::ADDR_BAUD_CTRL4, {2'h0, 2'(s), 4'h3});
         run16(0, sum, longs);
         check(sum, 16 * tick_gap(2'(s), 4'h3), "tap period");
      end
      for (int n = 0; n < 16; n++) begin
         reg_write(sbg_pkg::ADDR_BAUD_CTRL4, {4'h0, 4'(n)});
         run16(0, sum, longs);
         check(sum, 16 * tick_gap(2'h0, 4'(n)), "divisor");
      end
      // Fraction: two corners, then random legal N and K
      for (int i = 0; i < 8; i++) begin
         rnd = lfsr(rnd);
         nn = (i == 0) ? 4'h2 : (i == 1) ? 4'hf : 4'(2 + rnd % 14);
         rnd = lfsr(rnd);
         kk = (i == 0) ? 4'hf : (i == 1) ? 4'h1 : 4'(1 + rnd % 15);
         reg_write(sbg_pkg::ADDR_BAUD_CTRL4, {4'h0, nn});
         reg_write(sbg_pkg::ADDR_FRACTION_K4, {4'h0, kk});
         reg_write(sbg_pkg::ADDR_BAUD_CTRL4, {4'h4, nn});
         reg_read(sbg_pkg::ADDR_BAUD_CTRL4, d);
         check(d, {4'h4, nn}, "frac enable");
         run16(2 * (int'(nn) + 1), sum, longs);
         check(sum, 2 * (16 * int'(nn) + 16 - int'(kk)), "frac sum");
         check(longs, 16 - int'(kk), "long periods");
      end
      // Fraction off: K has no effect, sync mode and N of 1 included
      for (int i = 0; i < 3; i++) begin
         nn = (i == 2) ? 4'h1 : 4'h3;
         kk = (i == 1) ? 4'h0 : 4'h5;
         reg_write(sbg_pkg::ADDR_BAUD_CTRL4, 8'h00);
         reg_write(sbg_pkg::ADDR_FRACTION_K4, {4'h0, kk});
         reg_write(sbg_pkg::ADDR_CHAN_MODE4, (i == 0) ? 8'h00 : 8'h01);
         reg_write(sbg_pkg::ADDR_BAUD_CTRL4, {4'h0, nn});
         run16(0, sum, longs);
         check(sum, 16 * tick_gap(2'h0, nn), "frac off");
      end
      // Reset in mid-run clears the settings again
      @(posedge ref_clk);
      do_reset();
      reg_read(sbg_pkg::ADDR_BAUD_CTRL4, d);
      check(d, 8'h00, "baud after reset");
      check(run_enable, 4'hf, "run after reset");
      end_of_test();
   end
endmodule
